// ==== design/amp_ctrl_slave.sv ====
// control-port bus slave and register map of the four-channel amplifier
`timescale 1ns/1ps
`include "amp_regs.svh"

module amp_ctrl_slave (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    scl,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe,
  input  wire logic [1:0]              addr_sel,
  input  wire amp_pkg::amp_quad_t      fault_event,
  input  wire amp_pkg::amp_quad_t      status_live,
  input  wire logic                    fault_clear,
  output amp_pkg::amp_ctrl_bank_t      ctrl_regs
);
  import amp_pkg::*;

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------

  // offset lands in the writable control bank
  function automatic logic is_ctrl(input amp_byte_t a);
    is_ctrl = (a >= `AMP_REG_GAIN_SELECT_CTRL) && (a <= `AMP_MAP_LAST);
  endfunction

  // byte returned for an offset; unmapped offsets read zero
  function automatic amp_byte_t rd_byte(input amp_snap_t s, input amp_byte_t a);
    if (a <= `AMP_MAP_LAST) begin
      rd_byte = s[a[3:0]];
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  amp_link_state_t  state;
  logic [3:0]       bitcnt;
  logic             is_read;
  amp_byte_t        ptr;
  amp_byte_t        shreg;
  amp_byte_t        tx_sh;
  logic             sda_q;
  logic [1:0]       sel_m;
  logic [1:0]       sel_s;
  logic             start_tgl;
  logic             start_seen;
  logic             start_pend;
  logic             snap_tgl;
  logic             wr_tgl;
  amp_byte_t        wr_addr;
  amp_byte_t        wr_data;
  logic             dev_hit;
  amp_byte_t        rd_next_ptr;
  amp_byte_t        tx_now;
  amp_byte_t        tx_nxt;
  logic [1:0]       link_s;
  logic             wr_tgl_s;
  logic             snap_tgl_s;
  logic             wr_seen;
  logic             snap_seen;
  logic             wr_fire;
  logic             snap_fire;
  logic [64:0]      pin_s;
  amp_quad_t        ev_s;
  amp_quad_t        stat_s;
  logic             clr_s;
  amp_byte_t        latch [4];
  amp_ctrl_bank_t   ctrl;
  amp_snap_t        snap;
  amp_snap_t        next_snap;

  // --------------------------------------------------------------------------
  // link side: start detection on the data line
  // --------------------------------------------------------------------------

  // a falling data line while the bus clock is high opens a frame; data bits
  // only change with the clock low, so nothing else toggles this flag
  always_ff @(negedge sda_i or posedge rst) begin
    if (rst) begin
      start_tgl <= 1'b0;
    end else if (scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  assign start_pend = start_tgl ^ start_seen;

  // the start flag is settled by the next clock fall, a quarter bit later
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      start_seen <= 1'b0;
      snap_tgl   <= 1'b0;
    end else if (start_pend) begin
      start_seen <= start_tgl;
      snap_tgl   <= ~snap_tgl;
    end
  end

  // --------------------------------------------------------------------------
  // link side: bit sampling and pin straps
  // --------------------------------------------------------------------------

  // data is sampled on the rising bus clock
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      sda_q <= 1'b1;
      shreg <= 8'h00;
    end else begin
      sda_q <= sda_i;
      shreg <= {shreg[6:0], sda_i};
    end
  end

  // select pins pass two stages on the bus clock before the compare
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      sel_m <= 2'h0;
      sel_s <= 2'h0;
    end else begin
      sel_m <= addr_sel;
      sel_s <= sel_m;
    end
  end

  // --------------------------------------------------------------------------
  // link side: frame state machine, updated on the falling bus clock
  // --------------------------------------------------------------------------
  assign dev_hit     = shreg[7:1] == {`AMP_DEV_ADDR_HI, sel_s};
  assign rd_next_ptr = (ptr <= `AMP_LATCH_LAST) ? ptr : ptr + 8'h01;
  assign tx_now      = rd_byte(snap, ptr);
  assign tx_nxt      = rd_byte(snap, rd_next_ptr);
  assign sda_o       = 1'b0;

  // open drain: a zero bit or an acknowledge is a driven low
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      state   <= amp_st_idle;
      bitcnt  <= 4'h0;
      is_read <= 1'b0;
      ptr     <= 8'h00;
      tx_sh   <= 8'h00;
      sda_oe  <= 1'b0;
    end else if (start_pend) begin
      state  <= amp_st_dev;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        amp_st_idle: begin
          bitcnt <= 4'h0;
          sda_oe <= 1'b0;
        end
        amp_st_dev: begin
          if (bitcnt == 4'h7) begin
            if (dev_hit) begin
              sda_oe  <= 1'b1;
              is_read <= shreg[0];
              bitcnt  <= 4'h8;
            end else begin
              state  <= amp_st_idle;
              bitcnt <= 4'h0;
            end
          end else if (bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (is_read) begin
              state  <= amp_st_rdat;
              tx_sh  <= tx_now;
              sda_oe <= ~tx_now[7];
            end else begin
              state  <= amp_st_reg;
              sda_oe <= 1'b0;
            end
          end else begin
            bitcnt <= bitcnt + 4'h1;
          end
        end
        amp_st_reg: begin
          if (bitcnt == 4'h7) begin
            sda_oe <= 1'b1;
            ptr    <= shreg;
            bitcnt <= 4'h8;
          end else if (bitcnt == 4'h8) begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h0;
            state  <= amp_st_wdat;
          end else begin
            bitcnt <= bitcnt + 4'h1;
          end
        end
        amp_st_wdat: begin
          if (bitcnt == 4'h7) begin
            sda_oe <= 1'b1;
            bitcnt <= 4'h8;
          end else if (bitcnt == 4'h8) begin
            sda_oe <= 1'b0;
            ptr    <= ptr + 8'h01;
            bitcnt <= 4'h0;
          end else begin
            bitcnt <= bitcnt + 4'h1;
          end
        end
        amp_st_rdat: begin
          if (bitcnt == 4'h7) begin
            sda_oe <= 1'b0;
            bitcnt <= 4'h8;
          end else if (bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (!sda_q) begin
              ptr    <= rd_next_ptr;
              tx_sh  <= tx_nxt;
              sda_oe <= ~tx_nxt[7];
            end else begin
              state  <= amp_st_idle;
              sda_oe <= 1'b0;
            end
          end else begin
            sda_oe <= ~tx_sh[6];
            tx_sh  <= {tx_sh[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
          end
        end
      endcase
    end
  end

  // write hand-off: word is held until the next data byte, long after the
  // system side has seen the toggle
  always_ff @(negedge scl or posedge rst) begin
    if (rst) begin
      wr_tgl  <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (!start_pend && state == amp_st_wdat && bitcnt == 4'h7) begin
      wr_addr <= ptr;
      wr_data <= shreg;
      wr_tgl  <= ~wr_tgl;
    end
  end

  // --------------------------------------------------------------------------
  // system side: crossings
  // --------------------------------------------------------------------------
  amp_sync #(.WIDTH(2)) u_link_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({wr_tgl, snap_tgl}),
    .q       (link_s)
  );

  amp_sync #(.WIDTH(65)) u_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d       ({fault_clear, status_live, fault_event}),
    .q       (pin_s)
  );

  assign wr_tgl_s   = link_s[1];
  assign snap_tgl_s = link_s[0];
  assign ev_s       = pin_s[31:0];
  assign stat_s     = pin_s[63:32];
  assign clr_s      = pin_s[64];
  assign wr_fire    = wr_tgl_s != wr_seen;
  assign snap_fire  = snap_tgl_s != snap_seen;

  // --------------------------------------------------------------------------
  // system side: latched fault and diagnostic registers
  // --------------------------------------------------------------------------

  // an event in the clearing cycle still sets its bit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_latch
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          latch[gi] <= `AMP_RST_LATCH;
        end else begin
          latch[gi] <= (clr_s ? `AMP_RST_LATCH : latch[gi]) | ev_s[gi];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // system side: control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_seen <= 1'b0;
    end else begin
      wr_seen <= wr_tgl_s;
    end
  end

  // writes below the control bank or past the map are dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 2; i < 8; i++) begin
        ctrl[i] <= `AMP_RST_CTRL_OTHER;
      end
      ctrl[0] <= `AMP_RST_GAIN_SELECT_CTRL;
      ctrl[1] <= `AMP_RST_OFFSET_CURRENT_CTRL;
    end else if (wr_fire && is_ctrl(wr_addr)) begin
      ctrl[wr_addr[2:0]] <= wr_data;
    end
  end

  assign ctrl_regs = ctrl;

  // --------------------------------------------------------------------------
  // system side: read snapshot, taken at each start
  // --------------------------------------------------------------------------

  // the link reads this copy, which stays still between two starts
  always_comb begin
    next_snap = '0;
    for (int i = 0; i < 4; i++) begin
      next_snap[i]     = latch[i];
      next_snap[4 + i] = stat_s[i];
    end
    for (int i = 0; i < 8; i++) begin
      next_snap[8 + i] = ctrl[i];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snap_seen <= 1'b0;
      snap      <= '0;
    end else begin
      snap_seen <= snap_tgl_s;
      if (snap_fire) begin
        snap <= next_snap;
      end
    end
  end

  // --------------------------------------------------------------------------
  // assertions: link side
  // --------------------------------------------------------------------------
  a_addr_ack: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_dev && bitcnt == 4'h7 && dev_hit |=> sda_oe && bitcnt == 4'h8)
    else $error("own address not acknowledged");

  a_addr_foreign: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_dev && bitcnt == 4'h7 && !dev_hit |=> !sda_oe && state == amp_st_idle)
    else $error("foreign address answered");

  a_wdat_ack: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_wdat && bitcnt == 4'h7 |=> sda_oe ##1 !sda_oe)
    else $error("write data byte not acknowledged");

  a_wr_advance: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_wdat && bitcnt == 4'h8 |=> ptr == $past(ptr) + 8'h01)
    else $error("write pointer did not step");

  a_rd_advance: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_rdat && bitcnt == 4'h8 && !sda_q && ptr > `AMP_LATCH_LAST
    |=> ptr == $past(ptr) + 8'h01 && state == amp_st_rdat)
    else $error("read pointer did not step");

  a_fault_hold: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_rdat && bitcnt == 4'h8 && ptr <= `AMP_LATCH_LAST |=> $stable(ptr))
    else $error("pointer advanced through latched register");

  a_rd_msb: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_rdat && bitcnt < 4'h7 |=> sda_oe == !tx_now[3'd6 - $past(bitcnt[2:0])])
    else $error("read bit out of order");

  a_unmapped_zero: assert property (@(negedge scl) disable iff (rst)
    !start_pend && state == amp_st_rdat && bitcnt == 4'h8 && !sda_q && rd_next_ptr > `AMP_MAP_LAST
    |=> tx_sh == 8'h00 && sda_oe)
    else $error("unmapped read not zero");

  // --------------------------------------------------------------------------
  // assertions: system side
  // --------------------------------------------------------------------------
  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_fire && wr_addr == `AMP_REG_GAIN_SELECT_CTRL |=> ctrl[0] == $past(wr_data))
    else $error("control write lost");

  a_ro_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    wr_fire && !is_ctrl(wr_addr) |=> ctrl == $past(ctrl))
    else $error("read-only write changed control");

  a_global_set: assert property (@(posedge ref_clk) disable iff (rst)
    ev_s[0] != 8'h00 |=> (latch[0] & $past(ev_s[0])) == $past(ev_s[0]))
    else $error("global fault not latched");

  a_channel_keep: assert property (@(posedge ref_clk) disable iff (rst)
    !clr_s |=> (latch[1] & $past(latch[1])) == $past(latch[1]))
    else $error("channel fault dropped");

  a_diag_set: assert property (@(posedge ref_clk) disable iff (rst)
    clr_s ##0 ev_s[2] != 8'h00 |=> latch[2] == $past(ev_s[2]))
    else $error("diagnostic event lost on clear");

  a_latch_reset: assert property (@(posedge ref_clk)
    rst |=> latch[0] == 8'h00 && latch[1] == 8'h00 && latch[2] == 8'h00)
    else $error("latch not cleared by reset");

endmodule // amp_ctrl_slave

// ==== design/amp_pkg.sv ====
// types shared by the amplifier control slave
package amp_pkg;

  // --------------------------------------------------------------------------
  // data types
  // --------------------------------------------------------------------------
  typedef logic [7:0]         amp_byte_t;
  typedef amp_byte_t [7:0]    amp_ctrl_bank_t;
  typedef amp_byte_t [3:0]    amp_quad_t;
  typedef amp_byte_t [15:0]   amp_snap_t;

  // --------------------------------------------------------------------------
  // link state machine, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    amp_st_idle = 5'h01,
    amp_st_dev  = 5'h02,
    amp_st_reg  = 5'h04,
    amp_st_wdat = 5'h08,
    amp_st_rdat = 5'h10
  } amp_link_state_t;

endpackage

// ==== design/amp_regs.svh ====
// register map, bus address and reset constants of the amplifier control slave
`ifndef AMP_REGS_SVH
`define AMP_REGS_SVH

// ----------------------------------------------------------------------------
// bus address: fixed upper five bits, two more from the select pins
// ----------------------------------------------------------------------------
`define AMP_DEV_ADDR_HI              5'h1b

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define AMP_REG_GLOBAL_FAULT_LATCH   8'h00
`define AMP_REG_CHANNEL_FAULT_LATCH  8'h01
`define AMP_REG_LOAD_DIAG_LATCH_A    8'h02
`define AMP_REG_LOAD_DIAG_LATCH_B    8'h03
`define AMP_REG_TEMP_VOLTAGE_STATUS  8'h04
`define AMP_REG_OUTPUT_STATE_STATUS  8'h05
`define AMP_REG_PLAY_MUTE_STATUS     8'h06
`define AMP_REG_DIAG_MODE_STATUS     8'h07
`define AMP_REG_GAIN_SELECT_CTRL     8'h08
`define AMP_REG_OFFSET_CURRENT_CTRL  8'h09
`define AMP_REG_SWITCH_FREQ_CTRL     8'h0a
`define AMP_REG_DIAG_MASTER_CTRL     8'h0b
`define AMP_REG_OUTPUT_STATE_CTRL_A  8'h0c
`define AMP_REG_OUTPUT_STATE_CTRL_B  8'h0d
`define AMP_REG_DC_DETECT_LEVEL_A    8'h0e
`define AMP_REG_DC_DETECT_LEVEL_B    8'h0f

// last latched register (no read burst advance) and last mapped register
`define AMP_LATCH_LAST               8'h03
`define AMP_MAP_LAST                 8'h0f

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define AMP_RST_LATCH                8'h00
`define AMP_RST_GAIN_SELECT_CTRL     8'haa
`define AMP_RST_OFFSET_CURRENT_CTRL  8'h00
`define AMP_RST_CTRL_OTHER           8'h00

`endif

// ==== design/amp_sync.sv ====
// two flip-flop level synchroniser into the system clock domain
`timescale 1ns/1ps

module amp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // the first stage is read only by the second stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // amp_sync

// ==== tb/amp_bus_master.sv ====
// bus master model for the amplifier control port, open drain on sda
`timescale 1ns/1ps

module amp_bus_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // ---------------------------------------------------------------------------
  // bit timing: 160 ns bus clock, data moves in the middle of the low phase
  // ---------------------------------------------------------------------------
  localparam time QTR = 40ns;

  // scl stands high and sda released outside frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // start or repeated start: sda falls while scl is high
  task automatic start();
    sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b0;
  endtask

  // one bit; sampled mid-high, well clear of the device's falling-edge updates
  task automatic put_bit(input logic b, output logic seen);
    #QTR sda_low = ~b;
    #QTR scl = 1'b1;
    #QTR seen = sda;
    #QTR scl = 1'b0;
  endtask

  // byte out msb first, ninth bit released for the acknowledge
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // byte in; the last byte is answered high so the device lets go
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(last, s);
  endtask

  // stop: sda rises while scl is high
  task automatic stop();
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b0;
    #QTR;
  endtask

  // pointer byte then data bytes, one frame
  task automatic write_seq(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$], output int acks);
    logic a;
    acks = 0;
    start();
    send_byte({dev, 1'b0}, a);
    acks += a;
    send_byte(ptr, a);
    acks += a;
    foreach (d[i]) begin
      send_byte(d[i], a);
      acks += a;
    end
    stop();
  endtask

  // pointer load, repeated start, then n bytes back
  task automatic read_seq(input logic [6:0] dev, input logic [7:0] ptr, input int n, output logic [7:0] q[$],
                          output int acks);
    logic       a;
    logic [7:0] b;
    acks = 0;
    q = {};
    start();
    send_byte({dev, 1'b0}, a);
    acks += a;
    send_byte(ptr, a);
    acks += a;
    start();
    send_byte({dev, 1'b1}, a);
    acks += a;
    for (int i = 0; i < n; i++) begin
      recv_byte(i == n - 1, b);
      q.push_back(b);
    end
    stop();
  endtask
endmodule // amp_bus_master

// ==== tb/test_amp_ctrl_i2c_slave_regs.sv ====
// self-checking bench for the amplifier control slave
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end

module test_amp_ctrl_i2c_slave_regs;
  import amp_pkg::*;
  logic           ref_clk, rst, scl, sda_low, sda, sda_o, sda_oe, fault_clear;
  logic     [1:0] addr_sel;
  amp_quad_t      fault_event, status_live, exp_latch, ev;
  amp_ctrl_bank_t ctrl_regs, exp_ctrl;
  logic     [7:0] q[$], d[$];
  int             acks, errors, cmp_count;

  // wired-and bus with pull-up
  assign sda = ~sda_low & ~(sda_oe & ~sda_o);

  amp_ctrl_slave u_amp_ctrl_slave (.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .fault_event(fault_event), .status_live(status_live),
    .fault_clear(fault_clear), .ctrl_regs(ctrl_regs));
  amp_bus_master u_amp_bus_master (.scl(scl), .sda_low(sda_low), .sda(sda));

  // an unknown data line would read as a missing acknowledge and hide a fault
  always @(negedge scl) if (!rst) `CHK(sda === 1'b0 || sda === 1'b1, 1'b1)

  // ---------------------------------------------------------------------------
  // expectations
  // ---------------------------------------------------------------------------
  function automatic amp_byte_t exp_byte(input logic [7:0] p);
    if (p <= 8'h03) return exp_latch[p[1:0]];
    if (p <= 8'h07) return status_live[p[1:0]];
    if (p <= 8'h0f) return exp_ctrl[p[2:0]];
    return 8'h00;
  endfunction

  // random write burst; only mapped control bytes of an answered frame land
  task automatic wr_do(input logic [1:0] sel, input logic [7:0] ptr, input int n);
    logic [7:0] p;
    p = ptr;
    d = {};
    repeat (n) begin
      d.push_back(8'($urandom));
      if (sel == addr_sel && p >= 8'h08 && p <= 8'h0f) exp_ctrl[p[2:0]] = d[$];
      p++;
    end
    @(posedge ref_clk);
    #1;
    u_amp_bus_master.write_seq({5'h1b, sel}, ptr, d, acks);
    repeat (8) @(posedge ref_clk);
    `CHK(acks, (sel == addr_sel) ? n + 2 : 0)
    `CHK(ctrl_regs, exp_ctrl)
  endtask

  // read burst, compared byte by byte; latches hold the pointer
  task automatic rd_do(input logic [7:0] ptr, input int n);
    logic [7:0] p;
    p = ptr;
    @(posedge ref_clk);
    #1;
    u_amp_bus_master.read_seq({5'h1b, addr_sel}, ptr, n, q, acks);
    `CHK(acks, 3)
    foreach (q[i]) begin
      `CHK(q[i], exp_byte(p))
      if (p > 8'h03) p++;
    end
  endtask

  // hold fault inputs long enough to cross the synchroniser
  task automatic pulse(input amp_quad_t e, input logic clr);
    @(posedge ref_clk);
    #1;
    fault_event = e;
    fault_clear = clr;
    repeat (5) @(posedge ref_clk);
    #1;
    fault_event = '0;
    fault_clear = 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // the run needs about 0.3 ms; over six times that means a hang
  initial begin
    #2ms;
    errors++;
    stop_test();
  end

  initial begin
    rst = 1'b0;
    addr_sel = 2'b00;
    fault_event = '0;
    status_live = '0;
    fault_clear = 1'b0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(32'h4e57));
    exp_latch = '0;
    exp_ctrl = '0;
    exp_ctrl[0] = 8'haa;
    // raise reset after time zero so every asynchronous clear sees its edge
    #1 rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(ctrl_regs, exp_ctrl)
    `CHK(sda_oe, 1'b0)
    rd_do(8'h00, 1);
    rd_do(8'h08, 2);
    $display("test reset done");
    // every select setting: own address answered, a neighbour's refused
    for (int s = 0; s < 4; s++) begin
      addr_sel = 2'(s);
      wr_do(2'(s), 8'h08 + 8'(s), 1);
      wr_do(2'(s + 1), 8'h08 + 8'(s), 1);
    end
    $display("test address done");
    wr_do(addr_sel, 8'h0d, 4);
    wr_do(addr_sel, 8'h04, 2);
    status_live = amp_quad_t'($urandom);
    rd_do(8'h04, 7);
    rd_do(8'h10, 1);
    rd_do(8'hff, 1);
    rd_do(8'h0f, 2);
    $display("test map done");
    repeat (2) begin
      ev = amp_quad_t'($urandom);
      pulse(ev, 1'b0);
      exp_latch |= ev;
      rd_do(8'h00, 3);
      rd_do(8'h01, 2);
      rd_do(8'h02, 1);
      rd_do(8'h03, 1);
    end
    ev = amp_quad_t'($urandom);
    pulse(ev, 1'b1);
    exp_latch = ev;
    rd_do(8'h00, 1);
    rd_do(8'h02, 1);
    pulse('0, 1'b1);
    exp_latch = '0;
    rd_do(8'h01, 1);
    rd_do(8'h03, 1);
    $display("test latch done");
    repeat (6) begin
      automatic logic [7:0] p = 8'h08 + 8'($urandom_range(7));
      automatic int n = $urandom_range(3, 1);
      wr_do(addr_sel, p, n);
      rd_do(p, n + 1);
    end
    $display("test random done");
    // reset in mid-run, with latches set and control written, restores reset values
    pulse(amp_quad_t'($urandom) | 32'h0101_0101, 1'b0);
    #1 rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 rst = 1'b0;
    exp_latch = '0;
    exp_ctrl = '0;
    exp_ctrl[0] = 8'haa;
    repeat (4) @(posedge ref_clk);
    `CHK(ctrl_regs, exp_ctrl)
    rd_do(8'h00, 1);
    rd_do(8'h08, 2);
    $display("test reset again done");
    stop_test();
  end
endmodule // test_amp_ctrl_i2c_slave_regs
